// >>> rtl/pdt_pkg.sv
`default_nettype none

package pdt_pkg;

  // per-module live status
  typedef struct packed {
    logic       clk_on;
    logic       rst_rel;
    logic [5:0] state;
  } pdt_mod_t;

  // transition sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_DOMAIN,
    SEQ_SCAN,
    SEQ_MOVE
  } pdt_seq_t;

  // apb request as seen by the slave
  typedef struct packed {
    logic        sel;
    logic        en;
    logic        wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } pdt_apb_req_t;

endpackage

`default_nettype wire

// >>> rtl/pdt_power_domain_transition_control.sv
// Notes on behaviour
// - a write of one to the go bit while no transition runs compares every next-state field with the current state and moves each mismatch.
// - a write of zero to the go bit does nothing at all.
// - the busy status bit reads one while a transition runs and zero otherwise.
// - domain status bits 4 to 0 give the domain power state, zero off and one on.
// - domain status bit 8 shows the domain power-on reset, zero asserted and one released.
// - domain status bit 9 shows that the domain power-on reset has completed.
// - forty read-only module status registers exist, numbered 0 to 39.
// - module state codes are 0 sw-reset-disabled, 1 sync reset, 2 disabled, 3 enabled, 4 and up in transition.
// - module status bit 12 shows whether the module clock actually runs.
`include "pdt_regs.svh"
`default_nettype none

module pdt_power_domain_transition_control
  import pdt_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  output var  logic [39:0] module_clock_on,
  output var  logic [39:0] module_rst_n,
  output var  logic        domain_por_n,
  output var  logic        always_on_domain
);

  pdt_apb_req_t req;
  pdt_mod_t     mod_ff     [`PDT_NMOD];
  pdt_mod_t     nxt_mod    [`PDT_NMOD];
  logic [1:0]   mnext_ff   [`PDT_NMOD];
  logic [1:0]   nxt_mnext  [`PDT_NMOD];
  logic [39:0]  mismatch;
  logic [39:0]  pend_ff;
  logic [39:0]  nxt_pend;
  logic         dpend_ff;
  logic         nxt_dpend;
  logic         dnext_ff;
  logic         nxt_dnext;
  logic         dstate_ff;
  logic         nxt_dstate;
  logic         busy_ff;
  logic         nxt_busy;
  pdt_seq_t     st_ff;
  pdt_seq_t     nxt_st;
  logic [5:0]   idx_ff;
  logic [5:0]   nxt_idx;
  logic [7:0]   cnt_ff;
  logic [7:0]   nxt_cnt;
  logic [7:0]   por_cnt_ff;
  logic [7:0]   nxt_por_cnt;
  logic         por_rel_ff;
  logic         nxt_por_rel;
  logic         por_done_ff;
  logic         nxt_por_done;
  logic [31:0]  prdata_ff;
  logic [31:0]  nxt_prdata;
  logic         err_ff;
  logic         nxt_err;
  logic         wr_acc;
  logic         setup;
  logic         go;
  logic         is_md;
  logic         is_mctl;
  logic [5:0]   aidx;
  logic [31:0]  rd_val;

  // bundle the bus request
  assign req = '{sel: psel, en: penable, wr: pwrite, addr: paddr, wdata: pwdata};

  // decode: module pages hold one word per module, 40 words deep
  assign aidx     = req.addr[7:2];
  assign is_md    = (req.addr[11:8] == `PDT_PAGE_MSTAT) && (aidx <= `PDT_LAST_MOD);
  assign is_mctl  = (req.addr[11:8] == `PDT_PAGE_MCTL) && (aidx <= `PDT_LAST_MOD);
  assign setup    = req.sel && !req.en;
  assign wr_acc   = req.sel && req.en && req.wr;

  // go only on a one; a go during a running transition is dropped
  assign go = wr_acc && (req.addr == `PDT_OFF_CMD) && req.wdata[`PDT_GO_BIT] && !busy_ff;

  // per-module compare of next state against current state
  genvar g;
  generate
    for (g = 0; g < `PDT_NMOD; g++)
    begin : g_mod
      assign mismatch[g]        = (mod_ff[g].state != {4'h0, mnext_ff[g]});
      assign module_clock_on[g] = mod_ff[g].clk_on;
      assign module_rst_n[g]    = mod_ff[g].rst_rel && por_rel_ff;
    end
  endgenerate

  assign domain_por_n     = por_rel_ff;
  assign always_on_domain = dstate_ff;

  // read mux; evaluated in the setup cycle
  always_comb
  begin
    rd_val = 32'h0000_0000;
    if (is_md)
    begin
      rd_val[5:0]               = mod_ff[aidx].state;
      rd_val[`PDT_MD_LOCAL_BIT] = 1'b1;
      rd_val[`PDT_MD_LDONE_BIT] = 1'b1;
      rd_val[`PDT_MD_RST_BIT]   = mod_ff[aidx].rst_rel && por_rel_ff;
      rd_val[`PDT_MD_RSVD1_BIT] = 1'b1;
      rd_val[`PDT_MD_CLK_BIT]   = mod_ff[aidx].clk_on;
    end
    else if (is_mctl)
    begin
      rd_val[1:0] = mnext_ff[aidx];
    end
    else
    begin
      case (req.addr)
        `PDT_OFF_TSTAT:
        begin
          rd_val[`PDT_BUSY_BIT] = busy_ff;
        end
        `PDT_OFF_DSTAT:
        begin
          rd_val[4:0]              = {4'h0, dstate_ff};
          rd_val[`PDT_DS_POR_BIT]  = por_rel_ff;
          rd_val[`PDT_DS_DONE_BIT] = por_done_ff;
        end
        `PDT_OFF_DCTL:
        begin
          rd_val[`PDT_NEXT_BIT] = dnext_ff;
        end
        default:
        begin
          rd_val = 32'h0000_0000; // command reads as zero
        end
      endcase
    end
  end

  // bus answer: data and error latched at setup, ready in access
  always_comb
  begin
    nxt_prdata = prdata_ff;
    nxt_err    = err_ff;
    if (setup)
    begin
      nxt_prdata = req.wr ? 32'h0000_0000 : rd_val;
      nxt_err    = !(is_md || is_mctl || req.addr == `PDT_OFF_CMD || req.addr == `PDT_OFF_TSTAT
                     || req.addr == `PDT_OFF_DSTAT || req.addr == `PDT_OFF_DCTL);
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = req.sel && req.en; // one wait-free access cycle
  assign pslverr = req.sel && req.en && err_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_ff <= 32'h0000_0000;
      err_ff    <= 1'b0;
    end
    else
    begin
      prdata_ff <= nxt_prdata;
      err_ff    <= nxt_err;
    end
  end

  // power-on reset timer of the domain
  always_comb
  begin
    nxt_por_cnt  = por_cnt_ff;
    nxt_por_rel  = por_rel_ff;
    nxt_por_done = por_done_ff;
    if (por_cnt_ff != 8'h00)
    begin
      nxt_por_cnt = por_cnt_ff - 8'h01;
    end
    else if (!por_rel_ff)
    begin
      nxt_por_rel = 1'b1;
    end
    else
    begin
      nxt_por_done = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      por_cnt_ff  <= 8'(`PDT_POR_CYC);
      por_rel_ff  <= 1'b0;
      por_done_ff <= 1'b0;
    end
    else
    begin
      por_cnt_ff  <= nxt_por_cnt;
      por_rel_ff  <= nxt_por_rel;
      por_done_ff <= nxt_por_done;
    end
  end

  // sequencer: domain first, then modules one at a time in index order;
  // serial stepping keeps supply inrush low at the cost of latency
  always_comb
  begin
    nxt_mod    = mod_ff;
    nxt_mnext  = mnext_ff;
    nxt_pend   = pend_ff;
    nxt_dpend  = dpend_ff;
    nxt_dnext  = dnext_ff;
    nxt_dstate = dstate_ff;
    nxt_busy   = busy_ff;
    nxt_st     = st_ff;
    nxt_idx    = idx_ff;
    nxt_cnt    = cnt_ff;
    // control writes
    if (wr_acc && req.addr == `PDT_OFF_DCTL)
    begin
      nxt_dnext = req.wdata[`PDT_NEXT_BIT];
    end
    if (wr_acc && is_mctl)
    begin
      nxt_mnext[aidx] = req.wdata[1:0];
    end
    case (st_ff)
      SEQ_IDLE:
      begin
        if (go)
        begin
          nxt_pend  = mismatch;
          nxt_dpend = (dnext_ff != dstate_ff);
          nxt_idx   = 6'h00;
          if ((|mismatch) || (dnext_ff != dstate_ff))
          begin
            nxt_busy = 1'b1;
            nxt_st   = SEQ_DOMAIN;
          end
        end
      end
      SEQ_DOMAIN:
      begin
        if (dpend_ff)
        begin
          nxt_dstate = dnext_ff;
          nxt_dpend  = 1'b0;
        end
        nxt_st = SEQ_SCAN;
      end
      SEQ_SCAN:
      begin
        if (pend_ff[idx_ff])
        begin
          nxt_mod[idx_ff].state = `PDT_ST_TRANS;
          nxt_cnt               = 8'(`PDT_STEP_CYC - 1);
          nxt_st                = SEQ_MOVE;
        end
        else if (idx_ff == `PDT_LAST_MOD)
        begin
          nxt_busy = 1'b0;
          nxt_st   = SEQ_IDLE;
        end
        else
        begin
          nxt_idx = idx_ff + 6'h01;
        end
      end
      SEQ_MOVE:
      begin
        if (cnt_ff == 8'h00)
        begin
          // target taken live, so a late rewrite of the next state wins
          nxt_mod[idx_ff].state   = {4'h0, mnext_ff[idx_ff]};
          nxt_mod[idx_ff].clk_on  = ({4'h0, mnext_ff[idx_ff]} == `PDT_ST_ENABLE);
          nxt_mod[idx_ff].rst_rel = mnext_ff[idx_ff][1];
          nxt_pend[idx_ff]        = 1'b0;
          nxt_st                  = SEQ_SCAN;
        end
        else
        begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      default:
      begin
        nxt_st   = SEQ_IDLE;
        nxt_busy = 1'b0;
      end
    endcase
  end

  // sequencer and control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < `PDT_NMOD; i++)
      begin
        mod_ff[i]   <= '{clk_on: 1'b0, rst_rel: 1'b0, state: `PDT_ST_SWRSTDIS};
        mnext_ff[i] <= `PDT_RST_MNEXT;
      end
      pend_ff   <= 40'h00_0000_0000;
      dpend_ff  <= 1'b0;
      dnext_ff  <= `PDT_RST_DNEXT;
      dstate_ff <= `PDT_RST_DSTATE;
      busy_ff   <= 1'b0;
      st_ff     <= SEQ_IDLE;
      idx_ff    <= 6'h00;
      cnt_ff    <= 8'h00;
    end
    else
    begin
      mod_ff    <= nxt_mod;
      mnext_ff  <= nxt_mnext;
      pend_ff   <= nxt_pend;
      dpend_ff  <= nxt_dpend;
      dnext_ff  <= nxt_dnext;
      dstate_ff <= nxt_dstate;
      busy_ff   <= nxt_busy;
      st_ff     <= nxt_st;
      idx_ff    <= nxt_idx;
      cnt_ff    <= nxt_cnt;
    end
  end

endmodule // pdt_power_domain_transition_control

`default_nettype wire

// >>> rtl/pdt_regs.svh
`ifndef PDT_REGS_SVH
`define PDT_REGS_SVH

// register byte offsets
`define PDT_OFF_CMD        12'h120
`define PDT_OFF_TSTAT      12'h128
`define PDT_OFF_DSTAT      12'h200
`define PDT_OFF_DCTL       12'h300
`define PDT_PAGE_MSTAT     4'h8
`define PDT_PAGE_MCTL      4'hA

// module count and field layout
`define PDT_NMOD           40
`define PDT_LAST_MOD       6'h27
`define PDT_GO_BIT         0
`define PDT_BUSY_BIT       0
`define PDT_NEXT_BIT       0
`define PDT_DS_STATE_LSB   0
`define PDT_DS_POR_BIT     8
`define PDT_DS_DONE_BIT    9
`define PDT_MD_LOCAL_BIT   8
`define PDT_MD_LDONE_BIT   9
`define PDT_MD_RST_BIT     10
`define PDT_MD_RSVD1_BIT   11
`define PDT_MD_CLK_BIT     12

// module state codes
`define PDT_ST_SWRSTDIS    6'h00
`define PDT_ST_SYNCRST     6'h01
`define PDT_ST_DISABLE     6'h02
`define PDT_ST_ENABLE      6'h03
`define PDT_ST_TRANS       6'h04

// reset values
`define PDT_RST_DNEXT      1'h1
`define PDT_RST_DSTATE     1'h1
`define PDT_RST_MNEXT      2'h0

// timing: figures in ns, counts derived at 25 MHz
`define PDT_CLK_NS         40
`define PDT_STEP_NS        200
`define PDT_POR_NS         1000
`define PDT_STEP_CYC       ((`PDT_STEP_NS + `PDT_CLK_NS - 1) / `PDT_CLK_NS)
`define PDT_POR_CYC        ((`PDT_POR_NS + `PDT_CLK_NS - 1) / `PDT_CLK_NS)

`endif

// >>> testbench/pdt_properties.sv
`default_nettype none

module pdt_checker
  import pdt_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [39:0] module_clock_on,
  input wire logic [39:0] module_rst_n,
  input wire logic        domain_por_n,
  input wire logic        always_on_domain
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [8:0] quiet_ff;
  logic [8:0] nxt_quiet;
  logic [5:0] por_ff;
  logic [5:0] nxt_por;
  logic       mapped;

  // a go opens a window longer than the slowest transition
  always_comb
  begin
    nxt_quiet = (quiet_ff != 9'h0) ? quiet_ff - 9'h1 : 9'h0;
    if (psel && penable && pwrite && paddr == 12'h120 && pwdata[0])
      nxt_quiet = 9'h12C;
    nxt_por = (por_ff == 6'h3F) ? por_ff : por_ff + 6'h1; // saturates
    mapped = paddr == 12'h120 || paddr == 12'h128 || paddr == 12'h200 || paddr == 12'h300
      || ((paddr[11:8] == 4'h8 || paddr[11:8] == 4'hA) && paddr[7:0] <= 8'h9C);
  end

  // helper counters
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      quiet_ff <= 9'h0;
      por_ff   <= 6'h0;
    end
    else
    begin
      quiet_ff <= nxt_quiet;
      por_ff   <= nxt_por;
    end
  end

  sequence s_clk_step;
    $changed(module_clock_on);
  endsequence

  a_error_unmapped: assert property (psel && penable && paddr[1:0] == 2'h0 |-> pslverr == !mapped)
    else $error("slave error does not match address map");
  a_por_late: assert property (domain_por_n |-> por_ff >= 6'h19)
    else $error("domain reset released too early");
  a_por_on_time: assert property (por_ff >= 6'h1C |-> domain_por_n)
    else $error("domain reset not released in time");
  a_rst_under_por: assert property (!domain_por_n |-> module_rst_n == 40'h0)
    else $error("module reset released under domain reset");
  a_quiet_idle: assert property (quiet_ff == 9'h0 |=> $stable(module_clock_on) && $stable(module_rst_n))
    else $error("module outputs moved without a go");
  a_one_at_time: assert property ($onehot0(module_clock_on ^ $past(module_clock_on)))
    else $error("two module clocks changed at once");
  a_clock_gap: assert property (s_clk_step |=> $stable(module_clock_on) [*4])
    else $error("module steps closer than the transition time");
  a_clock_needs_rst: assert property (domain_por_n |-> (module_clock_on & ~module_rst_n) == 40'h0)
    else $error("module clock on while its reset is held");
endmodule // pdt_checker

bind pdt_power_domain_transition_control pdt_checker pdt_checker_inst
(
  .pclk             (pclk),
  .presetn          (presetn),
  .psel             (psel),
  .penable          (penable),
  .pwrite           (pwrite),
  .paddr            (paddr),
  .pwdata           (pwdata),
  .prdata           (prdata),
  .pready           (pready),
  .pslverr          (pslverr),
  .module_clock_on  (module_clock_on),
  .module_rst_n     (module_rst_n),
  .domain_por_n     (domain_por_n),
  .always_on_domain (always_on_domain)
);

`default_nettype wire

// >>> testbench/test_power_domain_transition_control.sv
`default_nettype none

module test_power_domain_transition_control;
  timeunit 1ns;
  timeprecision 1ns;
  import pdt_pkg::*;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [39:0] module_clock_on;
  logic [39:0] module_rst_n;
  logic        domain_por_n;
  logic        always_on_domain;
  logic [31:0] rd;
  logic        err;
  int          fails;
  int          n_tests;
  int          cyc;
  int          i;

  pdt_power_domain_transition_control pdt_power_domain_transition_control_inst
  (
    .pclk             (pclk),
    .presetn          (presetn),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .paddr            (paddr),
    .pwdata           (pwdata),
    .prdata           (prdata),
    .pready           (pready),
    .pslverr          (pslverr),
    .module_clock_on  (module_clock_on),
    .module_rst_n     (module_rst_n),
    .domain_por_n     (domain_por_n),
    .always_on_domain (always_on_domain)
  );

  // 25 MHz clock
  always #20 pclk = ~pclk;

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; an idle edge first so no signal is driven twice
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // hang guard, well above the expected few hundred cycles
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      fails++;
      test_done;
    end
  end

  initial
  begin
    pclk    = 1'b0;
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(12'h300, 32'h1);
    rdchk(12'h200, 32'h1);
    repeat (30) @(posedge pclk);
    rdchk(12'h200, 32'h301);
    chk({31'h0, always_on_domain}, 32'h1);
    for (i = 0; i < 40; i++)
      rdchk(12'h800 + 12'(4 * i), 32'h0B00);
    apb(1'b0, 12'h8A0, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, 12'h120, 32'h1);
    rdchk(12'h128, 32'h0);
    // let the checker's go window lapse so a stray move on a zero go is caught
    repeat (300) @(posedge pclk);
    apb(1'b1, 12'hA00, 32'h3);
    apb(1'b1, 12'hA14, 32'h1);
    apb(1'b1, 12'hA9C, 32'h2);
    apb(1'b1, 12'h120, 32'h0);
    rdchk(12'h128, 32'h0);
    rdchk(12'h800, 32'h0B00);
    apb(1'b1, 12'h120, 32'h1);
    rdchk(12'h128, 32'h1);
    // poll until the sequencer settles
    for (i = 0; i < 400 && rd[0] !== 1'b0; i++)
      apb(1'b0, 12'h128, 32'h0);
    chk(rd, 32'h0);
    rdchk(12'h800, 32'h1F03);
    rdchk(12'h814, 32'h0B01);
    rdchk(12'h89C, 32'h0F02);
    rdchk(12'h804, 32'h0B00);
    chk(module_clock_on[31:0], 32'h1);
    chk({24'h0, module_rst_n[39:32]}, 32'h80);
    apb(1'b1, 12'h200, 32'h0);
    rdchk(12'h200, 32'h301);
    rdchk(12'h120, 32'h0);
    test_done;
  end
endmodule // test_power_domain_transition_control

`default_nettype wire
